// [hw/cpg_pwm_generator.sv]
// PWM generator with AXI4-Lite register access and one output pin.
// Assumes a single 50 MHz clock and synchronous active-high reset.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpg_pwm_generator (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic pwm_pin,
  output logic pwm_pin_oe
);
  // Software registers
  logic [7:0] period_reg;
  logic [7:0] duty_reg;
  logic [7:0] shadow_reg;
  logic [1:0] lsb_latch_reg;
  logic [7:0] flags_reg;
  logic [7:0] enables_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] tcon_reg;
  logic [3:0] post_cnt_reg;
  logic pin_reg;
  // Bus state
  cpg_pkg::cpg_wstate_e ws_reg;
  cpg_pkg::cpg_rstate_e rs_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] waddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic [1:0] bresp_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  // Time base
  logic [7:0] timer;
  logic [9:0] ext_next;
  logic match;
  // Derived
  logic wr_fire;
  logic wr_byte;
  logic pwm_mode;
  logic [9:0] duty_buf;
  logic [9:0] duty_active;
  logic post_event;

  // True when an address names a register
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      cpg_pkg::OFF_PERIOD, cpg_pkg::OFF_DUTY, cpg_pkg::OFF_SHADOW,
      cpg_pkg::OFF_FLAGS, cpg_pkg::OFF_CTRL, cpg_pkg::OFF_TIMER,
      cpg_pkg::OFF_TCON, cpg_pkg::OFF_ENABLES: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  // True when a committed write with lane 0 hits the given offset
  function automatic logic hit(input logic [7:0] a);
    hit = wr_byte && waddr_reg == a;
  endfunction : hit

  // Time base instance
  cpg_timebase u_timebase (
    .sys_clk(sys_clk),
    .reset(reset),
    .timer_on(tcon_reg[cpg_pkg::TCON_ON]),
    .presc_sel(tcon_reg[1:0]),
    .period(period_reg),
    .timer(timer),
    .ext_next(ext_next),
    .match(match)
  );

  // Decode of mode, buffered and active duty
  assign pwm_mode = ctrl_reg[cpg_pkg::CTRL_MODE_LO +: 2] == cpg_pkg::PWM_MODE;
  assign duty_buf = {duty_reg, ctrl_reg[cpg_pkg::CTRL_LSB_LO +: 2]};
  assign duty_active = {shadow_reg, lsb_latch_reg};
  // Count left above a lowered postscale limit still fires at once
  assign post_event = match
      && post_cnt_reg >= tcon_reg[cpg_pkg::TCON_POST_LO +: 4];

  // Write handshakes: address and data accepted in either order
  assign s_axi_awready = ws_reg == cpg_pkg::CPG_W_IDLE && !aw_got_reg;
  assign s_axi_wready = ws_reg == cpg_pkg::CPG_W_IDLE && !w_got_reg;
  assign wr_fire = ws_reg == cpg_pkg::CPG_W_IDLE && aw_got_reg && w_got_reg;
  assign wr_byte = wr_fire && wstrb0_reg;
  assign s_axi_bvalid = ws_reg == cpg_pkg::CPG_W_RESP;
  assign s_axi_bresp = bresp_reg;

  // Write channel capture and response state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ws_reg <= cpg_pkg::CPG_W_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bresp_reg <= cpg_pkg::RESP_OKAY;
    end else begin
      case (ws_reg)
        cpg_pkg::CPG_W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
          end
          if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            ws_reg <= cpg_pkg::CPG_W_RESP;
            bresp_reg <= addr_mapped(waddr_reg) ? cpg_pkg::RESP_OKAY
                                                : cpg_pkg::RESP_SLVERR;
          end
        end
        cpg_pkg::CPG_W_RESP: begin
          if (s_axi_bready) begin
            ws_reg <= cpg_pkg::CPG_W_IDLE;
          end
        end
        default: ws_reg <= cpg_pkg::CPG_W_IDLE;
      endcase
    end
  end

  // Period, duty and timer control registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      period_reg <= cpg_pkg::RST_PERIOD;
      duty_reg <= cpg_pkg::RST_BYTE;
      ctrl_reg <= cpg_pkg::RST_BYTE;
      tcon_reg <= cpg_pkg::RST_BYTE;
      enables_reg <= cpg_pkg::RST_BYTE;
    end else begin
      if (hit(cpg_pkg::OFF_PERIOD)) begin
        period_reg <= wdata_reg;
      end
      if (hit(cpg_pkg::OFF_DUTY)) begin
        duty_reg <= wdata_reg;
      end
      if (hit(cpg_pkg::OFF_CTRL)) begin
        ctrl_reg <= wdata_reg & cpg_pkg::CTRL_MASK;
      end
      if (hit(cpg_pkg::OFF_TCON)) begin
        tcon_reg <= wdata_reg & cpg_pkg::TCON_MASK;
      end
      if (hit(cpg_pkg::OFF_ENABLES)) begin
        enables_reg <= wdata_reg & cpg_pkg::ENABLES_MASK;
      end
    end
  end

  // Shadow duty and hidden latch load only at the period match
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      shadow_reg <= cpg_pkg::RST_BYTE;
      lsb_latch_reg <= 2'h0;
    end else if (match) begin
      shadow_reg <= duty_buf[9:2];
      lsb_latch_reg <= duty_buf[1:0];
    end
  end

  // Postscaler counts matches to pace the flag only
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      post_cnt_reg <= 4'h0;
    end else if (match) begin
      post_cnt_reg <= post_event ? 4'h0 : post_cnt_reg + 4'h1;
    end
  end

  // Flags: software writes, hardware set wins over a clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_reg <= cpg_pkg::RST_BYTE;
    end else begin
      if (hit(cpg_pkg::OFF_FLAGS)) begin
        flags_reg <= wdata_reg & cpg_pkg::FLAGS_MASK;
      end
      if (post_event) begin
        flags_reg[cpg_pkg::FLAG_TMATCH] <= 1'b1;
      end
    end
  end

  // Output latch: set at period start, cleared at duty compare
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_reg <= 1'b0;
    end else if (!pwm_mode) begin
      pin_reg <= 1'b0;
    end else if (match) begin
      pin_reg <= duty_buf != 10'h000;
    end else if (ext_next == duty_active) begin
      pin_reg <= 1'b0;
    end
  end

  assign pwm_pin = pin_reg;
  assign pwm_pin_oe = pwm_mode;

  // Read channel: registered data, one beat per address
  assign s_axi_arready = rs_reg == cpg_pkg::CPG_R_IDLE;
  assign s_axi_rvalid = rs_reg == cpg_pkg::CPG_R_DATA;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rs_reg <= cpg_pkg::CPG_R_IDLE;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= cpg_pkg::RESP_OKAY;
    end else begin
      case (rs_reg)
        cpg_pkg::CPG_R_IDLE: begin
          if (s_axi_arvalid) begin
            rs_reg <= cpg_pkg::CPG_R_DATA;
            rresp_reg <= addr_mapped(s_axi_araddr) ? cpg_pkg::RESP_OKAY
                                                   : cpg_pkg::RESP_SLVERR;
            case (s_axi_araddr)
              cpg_pkg::OFF_PERIOD: rdata_reg <= {24'h000000, period_reg};
              cpg_pkg::OFF_DUTY: rdata_reg <= {24'h000000, duty_reg};
              cpg_pkg::OFF_SHADOW: rdata_reg <= {24'h000000, shadow_reg};
              cpg_pkg::OFF_FLAGS: rdata_reg <= {24'h000000, flags_reg};
              cpg_pkg::OFF_CTRL: rdata_reg <= {24'h000000, ctrl_reg};
              cpg_pkg::OFF_TIMER: rdata_reg <= {24'h000000, timer};
              cpg_pkg::OFF_TCON: rdata_reg <= {24'h000000, tcon_reg};
              cpg_pkg::OFF_ENABLES: rdata_reg <= {24'h000000, enables_reg};
              default: rdata_reg <= 32'h0000_0000;
            endcase
          end
        end
        cpg_pkg::CPG_R_DATA: begin
          if (s_axi_rready) begin
            rs_reg <= cpg_pkg::CPG_R_IDLE;
          end
        end
        default: rs_reg <= cpg_pkg::CPG_R_IDLE;
      endcase
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  // Period match seen with the timer at the period register
  sequence s_match;
    match && timer == period_reg;
  endsequence

  // Period start with a non-zero duty in PWM mode
  sequence s_start_high;
    pwm_mode && match && duty_buf != 10'h000;
  endsequence

  a_timer_wraps: assert property (
    s_match |=> timer == 8'h00)
    else $error("Timer did not clear after period match");

  a_pin_set_start: assert property (
    s_start_high ##1 pwm_mode |-> pin_reg)
    else $error("Pin not high at period start");

  a_zero_duty_low: assert property (
    pwm_mode && match && duty_buf == 10'h000 |=> !pin_reg)
    else $error("Pin set with zero duty");

  a_shadow_load: assert property (
    match |=> duty_active == $past(duty_buf))
    else $error("Shadow duty not loaded at match");

  a_shadow_stable: assert property (
    !match |=> $stable(duty_active))
    else $error("Shadow duty changed outside a match");

  a_pin_clears: assert property (
    pwm_mode && !match && pin_reg && ext_next == duty_active |=> !pin_reg)
    else $error("Pin not cleared at duty compare");

  a_long_duty_high: assert property (
    pwm_mode && !match && pin_reg && duty_active > {period_reg, 2'h3}
    |=> pin_reg)
    else $error("Pin cleared with duty beyond period");

  a_ctrl_zero_low: assert property (
    ctrl_reg == 8'h00 |=> !pin_reg)
    else $error("Output latch not low with control cleared");

  a_flag_sets: assert property (
    post_event |=> flags_reg[cpg_pkg::FLAG_TMATCH])
    else $error("Timer match flag not set");

  a_ccp_flag_quiet: assert property (
    !(wr_byte && waddr_reg == cpg_pkg::OFF_FLAGS)
    |=> !$rose(flags_reg[cpg_pkg::FLAG_CCP]))
    else $error("Capture flag set by hardware");

  a_unimpl_zero: assert property (
    (flags_reg & ~cpg_pkg::FLAGS_MASK) == 8'h00)
    else $error("Unimplemented flag bit set");

  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped before taken");

  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read data dropped before taken");

  a_busy_refuses: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write channel open while response pending");

  a_flag_paced: assert property (
    match && !post_event && !flags_reg[cpg_pkg::FLAG_TMATCH]
    && !(wr_byte && waddr_reg == cpg_pkg::OFF_FLAGS)
    |=> !flags_reg[cpg_pkg::FLAG_TMATCH])
    else $error("Timer match flag set between postscaler events");

  a_timer_frozen: assert property (
    !tcon_reg[cpg_pkg::TCON_ON] |=> $stable(timer))
    else $error("Period timer moved while stopped");

  a_no_pwm_low: assert property (
    !pwm_mode |=> !pin_reg)
    else $error("Pin high outside PWM mode");
endmodule : cpg_pwm_generator

// [hw/cpg_pkg.sv]
// Constants, register map and types of the PWM generator.
// Assumes a 50 MHz sys_clk that stands for the core oscillator.
package cpg_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned DUTY_W = 10;
  // Register byte addresses
  localparam logic [7:0] OFF_PERIOD = 8'h00;
  localparam logic [7:0] OFF_DUTY = 8'h04;
  localparam logic [7:0] OFF_SHADOW = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_TIMER = 8'h14;
  localparam logic [7:0] OFF_TCON = 8'h18;
  localparam logic [7:0] OFF_ENABLES = 8'h8C;
  // Reset values
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Implemented bits
  localparam logic [7:0] FLAGS_MASK = 8'h4F;
  localparam logic [7:0] ENABLES_MASK = 8'h4F;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] TCON_MASK = 8'h7F;
  // Field positions
  localparam int unsigned FLAG_TMATCH = 1;
  localparam int unsigned FLAG_CCP = 2;
  localparam int unsigned CTRL_LSB_LO = 4;
  localparam int unsigned CTRL_MODE_LO = 2;
  localparam int unsigned TCON_ON = 2;
  localparam int unsigned TCON_POST_LO = 3;
  localparam logic [1:0] PWM_MODE = 2'h3;
  // Prescale selections and their counter limits
  localparam logic [1:0] PRESC_1 = 2'h0;
  localparam logic [1:0] PRESC_4 = 2'h1;
  localparam logic [3:0] LIM_1 = 4'h0;
  localparam logic [3:0] LIM_4 = 4'h3;
  localparam logic [3:0] LIM_16 = 4'hF;
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    CPG_W_IDLE = 1'b0,
    CPG_W_RESP = 1'b1
  } cpg_wstate_e;
  typedef enum logic [0:0] {
    CPG_R_IDLE = 1'b0,
    CPG_R_DATA = 1'b1
  } cpg_rstate_e;
endpackage : cpg_pkg

// [hw/cpg_timebase.sv]
// Quarter-cycle counter, prescaler and 8-bit period timer.
// Assumes synchronous active-high reset on sys_clk.
`timescale 1ns/1ps
module cpg_timebase (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic timer_on,
  input wire logic [1:0] presc_sel,
  input wire logic [7:0] period,
  output logic [7:0] timer,
  output logic [9:0] ext_next,
  output logic match
);
  logic [1:0] q_reg;
  logic [3:0] presc_reg;
  logic [7:0] timer_reg;
  logic [3:0] limit;
  logic step;
  logic [1:0] q_next;
  logic [3:0] presc_next;
  logic [7:0] timer_next;
  logic [1:0] sub_next;

  // Prescale limit and the increment strobe
  always_comb begin
    case (presc_sel)
      cpg_pkg::PRESC_1: limit = cpg_pkg::LIM_1;
      cpg_pkg::PRESC_4: limit = cpg_pkg::LIM_4;
      default: limit = cpg_pkg::LIM_16;
    endcase
    step = timer_on && q_reg == cpg_pkg::Q_LAST && presc_reg >= limit;
    match = step && timer_reg == period;
  end

  // Next values of the counters
  always_comb begin
    q_next = timer_on ? q_reg + 2'h1 : q_reg;
    presc_next = presc_reg;
    if (timer_on && q_reg == cpg_pkg::Q_LAST) begin
      // A count left above a smaller new limit wraps at once
      presc_next = (presc_reg >= limit) ? 4'h0 : presc_reg + 4'h1;
    end
    timer_next = timer_reg;
    if (match) begin
      timer_next = 8'h00;
    end else if (step) begin
      timer_next = timer_reg + 8'h01;
    end
    // Two sub-cycle bits: quarter clock or prescaler bits
    case (presc_sel)
      cpg_pkg::PRESC_1: sub_next = q_next;
      cpg_pkg::PRESC_4: sub_next = presc_next[1:0];
      default: sub_next = presc_next[3:2];
    endcase
    ext_next = {timer_next, sub_next};
  end

  // Counter registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q_reg <= 2'h0;
      presc_reg <= 4'h0;
      timer_reg <= 8'h00;
    end else begin
      q_reg <= q_next;
      presc_reg <= presc_next;
      timer_reg <= timer_next;
    end
  end

  assign timer = timer_reg;
endmodule : cpg_timebase

// [sim/cpg_load_model.sv]
// Load model on the PWM pin: measures period and high time.
// Assumes the pin is pulled low whenever the block does not drive it.
`timescale 1ns/1ps
module cpg_load_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic pwm_pin,
  input wire logic pwm_pin_oe,
  output int rises,
  output int high_len,
  output int per_len
);
  logic lvl;
  logic pin_q;
  int cnt;
  int hcnt;
  // Level seen by the load, pulled low while undriven
  assign lvl = pwm_pin_oe & pwm_pin;
  // Count clocks between rising edges and while the pin is high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_q <= 1'h0;
      cnt <= 0;
      hcnt <= 0;
      rises <= 0;
      high_len <= 0;
      per_len <= 0;
    end else begin
      pin_q <= lvl;
      cnt <= cnt + 1;
      if (lvl) begin
        hcnt <= hcnt + 1;
      end
      if (lvl && !pin_q) begin
        per_len <= cnt;
        cnt <= 1;
        hcnt <= 1;
        rises <= rises + 1;
      end
      if (!lvl && pin_q) begin
        high_len <= hcnt;
      end
    end
  end
endmodule : cpg_load_model

// [sim/tb_ccp_pwm_generator.sv]
// Testbench of the PWM generator: register tasks and pin measurements.
// Assumes the design package and a 50 MHz clock, sync active-high reset.
`timescale 1ns/1ps
module tb_ccp_pwm_generator;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h1;
  logic [1:0] s_axi_bresp;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h1;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic pwm_pin;
  logic pwm_pin_oe;
  int rises;
  int high_len;
  int per_len;
  int bad_count = 0;
  int n_tests = 0;

  // Clock of 20 ns period
  always #10 sys_clk = ~sys_clk;

  cpg_pwm_generator u_dut (.sys_clk, .reset, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pwm_pin, .pwm_pin_oe);

  cpg_load_model u_load (.sys_clk, .reset, .pwm_pin, .pwm_pin_oe, .rises,
    .high_len, .per_len);

  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : chk

  // Bus write; valids dropped at the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    logic ah;
    logic wh;
    logic bh;
    logic [1:0] rsp;
    n = 0;
    bh = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!bh && n < 200) begin
      @(negedge sys_clk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge sys_clk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
      n++;
    end
    if (!bh) begin
      chk("write answer", 32'h1, 32'h0);
      results();
    end
    chk("bresp", {30'h0, er}, {30'h0, rsp});
  endtask : wr

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    int n;
    logic ah;
    logic rh;
    logic [31:0] dat;
    logic [1:0] rsp;
    n = 0;
    rh = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    while (!rh && n < 200) begin
      @(negedge sys_clk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      dat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge sys_clk);
      if (ah) s_axi_arvalid <= 1'h0;
      n++;
    end
    if (!rh) begin
      chk("read answer", 32'h1, 32'h0);
      results();
    end
    chk("rdata", {24'h0, ed}, dat);
    chk("rresp", {30'h0, er}, {30'h0, rsp});
  endtask : rd

  // Wait three pin periods, then compare the last complete one
  task automatic measure(input int eh, input int ep);
    int r0;
    int n;
    r0 = rises;
    n = 0;
    while (rises < r0 + 3 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    if (n >= 3000) begin
      chk("pin periods", 32'h1, 32'h0);
      results();
    end
    chk("high time", eh, high_len);
    chk("period", ep, per_len);
  endtask : measure

  // Pin must keep one level for a number of clocks
  task automatic hold(input logic lv, input int cyc);
    logic ok;
    ok = 1'h1;
    repeat (cyc) begin
      @(negedge sys_clk);
      if (pwm_pin !== lv) ok = 1'h0;
    end
    @(posedge sys_clk);
    chk("pin steady", 32'h1, {31'h0, ok});
  endtask : hold

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'h0;
    @(posedge sys_clk);
    chk("oe after reset", 32'h0, {31'h0, pwm_pin_oe});
    rd(cpg_pkg::OFF_PERIOD, 8'hFF, cpg_pkg::RESP_OKAY);
    rd(cpg_pkg::OFF_FLAGS, 8'h00, cpg_pkg::RESP_OKAY);
    rd(cpg_pkg::OFF_ENABLES, 8'h00, cpg_pkg::RESP_OKAY);
    rd(8'h20, 8'h00, cpg_pkg::RESP_SLVERR);
    wr(8'h24, 8'h11, cpg_pkg::RESP_SLVERR);
    wr(cpg_pkg::OFF_FLAGS, 8'hFF, cpg_pkg::RESP_OKAY);
    rd(cpg_pkg::OFF_FLAGS, 8'h4F, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_ENABLES, 8'hFF, cpg_pkg::RESP_OKAY);
    rd(cpg_pkg::OFF_ENABLES, 8'h4F, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_ENABLES, 8'h00, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_FLAGS, 8'h00, cpg_pkg::RESP_OKAY);
    rd(cpg_pkg::OFF_FLAGS, 8'h00, cpg_pkg::RESP_OKAY);
    // Period 3, duty {02,01} = 9, prescale 1
    wr(cpg_pkg::OFF_PERIOD, 8'h03, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_DUTY, 8'h02, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_CTRL, 8'h1C, cpg_pkg::RESP_OKAY);
    chk("oe in pwm mode", 32'h1, {31'h0, pwm_pin_oe});
    wr(cpg_pkg::OFF_TCON, 8'h04, cpg_pkg::RESP_OKAY);
    measure(9, 16);
    rd(cpg_pkg::OFF_SHADOW, 8'h02, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_SHADOW, 8'h55, cpg_pkg::RESP_OKAY);
    rd(cpg_pkg::OFF_SHADOW, 8'h02, cpg_pkg::RESP_OKAY);
    // Write with lane 0 disabled leaves the period unchanged
    s_axi_wstrb <= 4'h0;
    wr(cpg_pkg::OFF_PERIOD, 8'h77, cpg_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(cpg_pkg::OFF_PERIOD, 8'h03, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_FLAGS, 8'h00, cpg_pkg::RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    rd(cpg_pkg::OFF_FLAGS, 8'h02, cpg_pkg::RESP_OKAY);
    // Stopped timer: a new duty must wait for the next match
    wr(cpg_pkg::OFF_TCON, 8'h00, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_DUTY, 8'h01, cpg_pkg::RESP_OKAY);
    rd(cpg_pkg::OFF_SHADOW, 8'h02, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_TCON, 8'h1C, cpg_pkg::RESP_OKAY);
    measure(5, 16);
    // Every prescale selection: 1, 4 and 16
    for (int i = 0; i < 3; i++) begin
      wr(cpg_pkg::OFF_TCON, 8'h04 | 8'(i), cpg_pkg::RESP_OKAY);
      measure(5 << (2 * i), 16 << (2 * i));
    end
    // Duty longer than the period keeps the pin high
    wr(cpg_pkg::OFF_TCON, 8'h04, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_DUTY, 8'hFF, cpg_pkg::RESP_OKAY);
    repeat (40) @(posedge sys_clk);
    hold(1'h1, 40);
    wr(cpg_pkg::OFF_CTRL, 8'h00, cpg_pkg::RESP_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("pin after clear", 32'h0, {31'h0, pwm_pin});
    chk("oe after clear", 32'h0, {31'h0, pwm_pin_oe});
    // Zero duty never sets the pin
    wr(cpg_pkg::OFF_DUTY, 8'h00, cpg_pkg::RESP_OKAY);
    wr(cpg_pkg::OFF_CTRL, 8'h0C, cpg_pkg::RESP_OKAY);
    repeat (40) @(posedge sys_clk);
    hold(1'h0, 40);
    chk("oe zero duty", 32'h1, {31'h0, pwm_pin_oe});
    results();
  end
endmodule : tb_ccp_pwm_generator
